/* File: hdl/bcs_top.sv */
// two-wire bus condition, arbitration and clock line control
// Functional notes
// - flag start and stop seen on the bus
// - request bits generate start, restart, stop
// - select picks detect or generation event timing
// - compare sent bit with line at clock rise
// - per-bit mode: lost flag follows each check
// - per-byte mode: lost flag set after ninth
// - release data the moment loss flag sets
// - eighth-bit wait holds clock low until cleared
// - force-low bit holds clock low anytime
// - ninth-bit wait holds clock when delay selected
// - early bus clock fall restarts internal clock
// - high phase pauses while bus clock low
// - stop during transfer releases clock line
// - internal clock halves are equal length
// - nine-bit word, MSB first, ninth from word bit 8
// - data output delayed zero to eight cycles
// - data-disable forces data line released
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "bcs_regs.svh"
module bcs_top
    import bcs_pkg::*;
#(
    parameter int BAUD_W = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // bus clock pin, open drain
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe_n,
    // bus data pin, open drain
    input wire logic serial_data_pin_i,
    output logic serial_data_pin_o,
    output logic serial_data_pin_oe_n,
    // condition event pulses
    output logic start_irq,
    output logic stop_irq
);

    typedef struct packed {
        bcs_state_t state;          // sequencer state
        bcs_cond_t cond;            // condition being generated
        logic [1:0] ph;             // phase within a condition
        logic [BAUD_W-1:0] cnt;     // half-period down counter
        logic [3:0] bit_idx;        // bit within byte, 0..8
        logic [8:0] txw;            // transmit word
        logic [`BCS_CTRL_W-1:0] ctrl; // control bits
        logic [BAUD_W-1:0] baud;    // divider value
        logic lost;                 // arbitration lost flag
        logic miss;                 // mismatch seen during byte
        logic loss_hold;            // data kept off after loss
        logic own;                  // we hold the bus after start
        logic seen_high;            // bus clock seen high this phase
        logic sda_pend;             // next data level, before delay
        logic sda_rel;              // data level after delay
        logic [3:0] dly;            // remaining data delay cycles
        logic scl_oe_n;             // clock pin released
        logic sda_oe_n;             // data pin released
        logic [31:0] rdata;
        logic start_irq;
        logic stop_irq;
    } bcs_st_t;

    bcs_st_t s;
    bcs_st_t next_s;
    bcs_pin_if pin_bus ();

    // pin synchroniser and condition detector
    bcs_pins u_pins (
        .mclk(mclk),
        .rst_n(rst_n),
        .scl_raw(serial_clock_pin_i),
        .sda_raw(serial_data_pin_i),
        .pins(pin_bus.src)
    );

    // one transmit bit; the ninth always comes from bit 8
    function automatic logic tx_bit(input logic [8:0] w,
                                    input logic [3:0] idx,
                                    input logic msb);
        logic [2:0] k;
        k = msb ? (3'h7 - idx[2:0]) : idx[2:0];
        if (idx == `BCS_LAST_BIT) begin
            tx_bit = w[8];
        end else begin
            tx_bit = w[k];
        end
    endfunction

    // delay setting to cycles; top code stretches to eight
    function automatic logic [3:0] dly_cycles(input logic [2:0] f);
        if (f == `BCS_DL_MAX) begin
            dly_cycles = `BCS_DL_TOP;
        end else begin
            dly_cycles = {1'b0, f};
        end
    endfunction

    // pin pattern {clock released, data released} per phase
    function automatic logic [1:0] cond_pins(input bcs_cond_t c,
                                             input logic [1:0] p);
        unique case (c)
            cond_start: begin
                cond_pins = (p == 2'h0) ? 2'b11 :
                            (p == 2'h1) ? 2'b10 : 2'b00;
            end
            cond_restart: begin
                cond_pins = (p == 2'h0) ? 2'b01 :
                            (p == 2'h1) ? 2'b11 :
                            (p == 2'h2) ? 2'b10 : 2'b00;
            end
            default: begin
                cond_pins = (p == 2'h0) ? 2'b00 :
                            (p == 2'h1) ? 2'b10 : 2'b11;
            end
        endcase
    endfunction

    // last phase of each condition
    function automatic logic [1:0] cond_last(input bcs_cond_t c);
        cond_last = (c == cond_restart) ? 2'h3 : 2'h2;
    endfunction

    logic sel;
    logic busy;
    logic tick;
    logic tx_go;
    logic mism;
    logic fall_now;
    logic scl_rel;
    logic [1:0] cp;

    assign sel = s.ctrl[`BCS_C_SEL];
    assign busy = (s.state != st_idle);
    // half period is baud+1 cycles for both halves, so duty is even
    // equal halves
    assign tick = (s.cnt == '0);
    assign tx_go = wr && (addr == `BCS_A_TX) && (s.state == st_idle)
                   && !sel;

    // next-state logic: registers, sequencer, arbitration, pins
    always_comb begin
        next_s = s;
        next_s.start_irq = 1'b0;
        next_s.stop_irq = 1'b0;
        next_s.rdata = 32'h0;
        mism = 1'b0;
        fall_now = 1'b0;
        scl_rel = 1'b1;
        cp = 2'b11;

        // software writes
        if (wr) begin
            unique case (addr)
                `BCS_A_CTRL: next_s.ctrl = wdata[`BCS_CTRL_W-1:0];
                `BCS_A_BAUD: next_s.baud = wdata[BAUD_W-1:0];
                `BCS_A_TX: next_s.txw = wdata[8:0];
                // writing zero to the loss flag clears it
                `BCS_A_STAT: begin
                    if (!wdata[`BCS_S_LOST]) begin
                        next_s.lost = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // read data lands the cycle after the strobe, zero elsewhere
        if (rd) begin
            unique case (addr)
                `BCS_A_CTRL: next_s.rdata = 32'(s.ctrl);
                `BCS_A_BAUD: next_s.rdata = 32'(s.baud);
                `BCS_A_TX: next_s.rdata = 32'(s.txw);
                `BCS_A_STAT: begin
                    next_s.rdata[`BCS_S_LOST] = s.lost;
                    next_s.rdata[`BCS_S_BUSY] = busy;
                    next_s.rdata[`BCS_S_SCL] = pin_bus.scl;
                    next_s.rdata[`BCS_S_SDA] = pin_bus.sda;
                    next_s.rdata[`BCS_S_OWN] = s.own;
                end
                default: begin
                end
            endcase
        end

        if (!sel) begin
            next_s.start_irq = pin_bus.start_det;
            next_s.stop_irq = pin_bus.stop_det;
        end

        if (s.dly != 4'h0) begin
            next_s.dly = s.dly - 4'h1;
        end else begin
            next_s.sda_rel = s.sda_pend;
        end

        // half-period counter runs down; states reload it
        if (!tick) begin
            next_s.cnt = s.cnt - BAUD_W'(1);
        end

        unique case (s.state)
            st_idle: begin
                if (sel && (s.ctrl[`BCS_C_STA] || s.ctrl[`BCS_C_RSTA]
                            || s.ctrl[`BCS_C_STP])) begin
                    next_s.cond = s.ctrl[`BCS_C_STA] ? cond_start :
                                  s.ctrl[`BCS_C_RSTA] ? cond_restart :
                                  cond_stop;
                    next_s.ph = 2'h0;
                    next_s.cnt = s.baud;
                    next_s.state = st_cond;
                end else if (tx_go) begin
                    next_s.bit_idx = 4'h0;
                    next_s.cnt = s.baud;
                    next_s.miss = 1'b0;
                    next_s.loss_hold = 1'b0;
                    next_s.sda_pend = tx_bit(wdata[8:0], 4'h0,
                                             s.ctrl[`BCS_C_MSB]);
                    next_s.dly = dly_cycles(
                        s.ctrl[`BCS_C_DL_HI:`BCS_C_DL_LO]);
                    next_s.state = st_low;
                end
            end
            st_cond: begin
                if (tick) begin
                    if (s.ph == cond_last(s.cond)) begin
                        next_s.state = st_idle;
                        if (s.cond == cond_stop) begin
                            next_s.stop_irq = 1'b1;
                            next_s.own = 1'b0;
                            next_s.ctrl[`BCS_C_STP] = 1'b0;
                        end else begin
                            next_s.start_irq = 1'b1;
                            next_s.own = 1'b1;
                            next_s.ctrl[`BCS_C_STA] = 1'b0;
                            next_s.ctrl[`BCS_C_RSTA] = 1'b0;
                        end
                    end else begin
                        next_s.ph = s.ph + 2'h1;
                        next_s.cnt = s.baud;
                    end
                end
            end
            st_low: begin
                if (tick && !((s.bit_idx == `BCS_LAST_BIT)
                              && s.ctrl[`BCS_C_WAIT8])) begin
                    next_s.state = st_high;
                    next_s.cnt = s.baud;
                    next_s.seen_high = 1'b0;
                end
            end
            st_high: begin
                if (pin_bus.scl) begin
                    next_s.seen_high = 1'b1;
                end
                if (s.ctrl[`BCS_C_SYNC] && s.seen_high
                    && pin_bus.scl_fall) begin
                    fall_now = 1'b1;
                end else if (s.ctrl[`BCS_C_SYNC] && !pin_bus.scl) begin
                    next_s.cnt = s.cnt;
                end else if (tick) begin
                    fall_now = 1'b1;
                end
            end
            st_wait: begin
                if (!(s.ctrl[`BCS_C_DLYSEL] && s.ctrl[`BCS_C_WAIT9])) begin
                    next_s.state = st_idle;
                end
            end
            default: begin
                next_s.state = st_idle;
            end
        endcase

        // falling edge of the internal clock
        if (fall_now) begin
            next_s.cnt = s.baud;
            if (s.bit_idx == `BCS_LAST_BIT) begin
                if (s.ctrl[`BCS_C_ABC] && s.miss) begin
                    next_s.lost = 1'b1;
                end
                next_s.loss_hold = 1'b0;
                next_s.own = 1'b1;
                next_s.state = (s.ctrl[`BCS_C_DLYSEL]
                                && s.ctrl[`BCS_C_WAIT9]) ? st_wait
                                                           : st_idle;
            end else begin
                next_s.bit_idx = s.bit_idx + 4'h1;
                next_s.sda_pend = tx_bit(s.txw, s.bit_idx + 4'h1,
                                         s.ctrl[`BCS_C_MSB]);
                next_s.dly = dly_cycles(
                    s.ctrl[`BCS_C_DL_HI:`BCS_C_DL_LO]);
                next_s.state = st_low;
            end
        end

        // check at clock rise; the ninth bit is the ack slot
        if (pin_bus.scl_rise && (s.state == st_high)
            && (s.bit_idx != `BCS_LAST_BIT)) begin
            mism = s.sda_rel && !pin_bus.sda;
            if (!s.ctrl[`BCS_C_ABC]) begin
                next_s.lost = mism;
            end else if (mism) begin
                next_s.miss = 1'b1;
            end
        end

        if (next_s.lost && !s.lost && s.ctrl[`BCS_C_ALS] && busy) begin
            next_s.loss_hold = 1'b1;
        end

        // stop from elsewhere ends the transfer
        if (busy && (s.state != st_cond) && pin_bus.stop_det
            && s.ctrl[`BCS_C_RELSTOP]) begin
            next_s.state = st_idle;
            next_s.own = 1'b0;
            next_s.loss_hold = 1'b0;
            next_s.sda_pend = 1'b1;
            next_s.dly = 4'h0;
        end

        // conditions drive the data line directly, no delay
        if (next_s.state == st_cond) begin
            cp = cond_pins(next_s.cond, next_s.ph);
            next_s.sda_pend = cp[0];
            next_s.sda_rel = cp[0];
            next_s.dly = 4'h0;
        end

        // clock line from the next state
        unique case (next_s.state)
            st_idle: scl_rel = !next_s.own;
            st_cond: scl_rel = cp[1];
            st_high: scl_rel = 1'b1;
            default: scl_rel = 1'b0;
        endcase

        next_s.scl_oe_n = scl_rel && !next_s.ctrl[`BCS_C_FLOW];
        next_s.sda_oe_n = next_s.sda_rel || next_s.loss_hold
                          || next_s.ctrl[`BCS_C_SDDIS];
    end

    // state register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s <= '0;
            s.state <= st_idle;
            s.cond <= cond_start;
            s.ctrl <= `BCS_CTRL_RST;
            s.baud <= `BCS_BAUD_RST;
            s.txw <= `BCS_TX_RST;
            s.sda_pend <= 1'b1;
            s.sda_rel <= 1'b1;
            s.scl_oe_n <= 1'b1;
            s.sda_oe_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // open-drain pins only ever pull low
    assign serial_clock_pin_o = 1'b0;
    assign serial_data_pin_o = 1'b0;
    assign serial_clock_pin_oe_n = s.scl_oe_n;
    assign serial_data_pin_oe_n = s.sda_oe_n;
    assign rdata = s.rdata;
    assign start_irq = s.start_irq;
    assign stop_irq = s.stop_irq;

endmodule

/* File: hdl/bcs_regs.svh */
// register offsets, field positions, reset values and counts of the block
`ifndef BCS_REGS_SVH
`define BCS_REGS_SVH

// register byte offsets
`define BCS_A_CTRL 8'h00
`define BCS_A_BAUD 8'h04
`define BCS_A_TX 8'h08
`define BCS_A_STAT 8'h0c

// control register fields
`define BCS_C_STA 0
`define BCS_C_RSTA 1
`define BCS_C_STP 2
`define BCS_C_SEL 3
`define BCS_C_WAIT8 4
`define BCS_C_FLOW 5
`define BCS_C_WAIT9 6
`define BCS_C_DLYSEL 7
`define BCS_C_SYNC 8
`define BCS_C_CKSRC 9
`define BCS_C_RELSTOP 10
`define BCS_C_MSB 11
`define BCS_C_SDDIS 12
`define BCS_C_ABC 13
`define BCS_C_ALS 14
`define BCS_C_DL_LO 15
`define BCS_C_DL_HI 17
`define BCS_CTRL_W 18

// status register fields
`define BCS_S_LOST 0
`define BCS_S_BUSY 1
`define BCS_S_SCL 2
`define BCS_S_SDA 3
`define BCS_S_OWN 4

// reset values
`define BCS_CTRL_RST 18'h00800
`define BCS_BAUD_RST 8'h18
`define BCS_TX_RST 9'h1ff

// counts
`define BCS_HOLD_CYC 3'h6
`define BCS_LAST_BIT 4'h8
`define BCS_DL_MAX 3'h7
`define BCS_DL_TOP 4'h8

`endif

/* File: hdl/bcs_pkg.sv */
// types shared by the bus condition and clock control block
package bcs_pkg;

    // sequencer states
    typedef enum logic [2:0] {
        st_idle,
        st_cond,
        st_low,
        st_high,
        st_wait
    } bcs_state_t;

    // bus condition being generated
    typedef enum logic [1:0] {
        cond_start,
        cond_restart,
        cond_stop
    } bcs_cond_t;

endpackage

/* File: hdl/bcs_pin_if.sv */
// synchronised pin levels and detected bus events
`timescale 1ns/10ps
interface bcs_pin_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    modport src (
        output scl, sda, scl_rise, scl_fall, start_det, stop_det
    );
    modport sink (
        input scl, sda, scl_rise, scl_fall, start_det, stop_det
    );
endinterface

/* File: hdl/bcs_pins.sv */
// pin synchroniser and start/stop condition detector
`timescale 1ns/10ps
`include "bcs_regs.svh"
module bcs_pins
    import bcs_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // raw pin levels
    input wire logic scl_raw,
    input wire logic sda_raw,
    // cleaned levels and events
    bcs_pin_if.src pins
);

    typedef struct packed {
        logic scl_m;          // first stage, read only by second
        logic sda_m;
        logic scl_s;          // synchronised levels
        logic sda_s;
        logic scl_q;          // delayed copy for edges
        logic sda_q;
        logic [2:0] high_cnt; // cycles scl has been high (setup)
        logic pend;           // condition seen, waiting out hold
        logic pend_stop;      // pending one is a stop
        logic [2:0] hold_cnt; // cycles scl stayed high after edge
        logic start_det;
        logic stop_det;
    } bcs_pin_st_t;

    bcs_pin_st_t s;
    bcs_pin_st_t next_s;

    // detection: a data edge under a high clock, guarded both sides
    always_comb begin
        next_s = s;
        next_s.scl_m = scl_raw;
        next_s.sda_m = sda_raw;
        next_s.scl_s = s.scl_m;
        next_s.sda_s = s.sda_m;
        next_s.scl_q = s.scl_s;
        next_s.sda_q = s.sda_s;
        next_s.start_det = 1'b0;
        next_s.stop_det = 1'b0;
        // setup counter saturates at the guard count
        if (!s.scl_s) begin
            next_s.high_cnt = 3'h0;
        end else if (s.high_cnt != `BCS_HOLD_CYC) begin
            next_s.high_cnt = s.high_cnt + 3'h1;
        end
        if (s.pend) begin
            // clock dropped or data bounced: glitch, not a condition
            if (!s.scl_s || (s.sda_s != s.sda_q)) begin
                next_s.pend = 1'b0;
            end else if (s.hold_cnt == `BCS_HOLD_CYC - 3'h1) begin
                next_s.pend = 1'b0;
                next_s.start_det = !s.pend_stop;
                next_s.stop_det = s.pend_stop;
            end else begin
                next_s.hold_cnt = s.hold_cnt + 3'h1;
            end
        end else if (s.scl_s && s.scl_q && (s.sda_s != s.sda_q)
                     && (s.high_cnt == `BCS_HOLD_CYC)) begin
            next_s.pend = 1'b1;
            next_s.pend_stop = s.sda_s;
            next_s.hold_cnt = 3'h0;
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pins.scl = s.scl_s;
    assign pins.sda = s.sda_s;
    assign pins.scl_rise = s.scl_s && !s.scl_q;
    assign pins.scl_fall = !s.scl_s && s.scl_q;
    assign pins.start_det = s.start_det;
    assign pins.stop_det = s.stop_det;

endmodule

/* File: tb/bcs_sva.sv */
// port checker for the bus condition and clock block
`timescale 1ns/10ps
`include "bcs_regs.svh"
module bcs_sva (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    // pins and events
    input wire logic serial_clock_pin_o,
    input wire logic serial_clock_pin_oe_n,
    input wire logic serial_data_pin_o,
    input wire logic serial_data_pin_oe_n,
    input wire logic start_irq,
    input wire logic stop_irq
);
    logic [31:0] ctl; // shadow of control, only sticky bits used
    logic [1:0] age; // edges since last control write, saturates
    // shadow control so pin rules can be tied to the setting
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctl <= 32'h00000800;
            age <= 2'h0;
        end else if (wr && addr == `BCS_A_CTRL) begin
            ctl <= wdata;
            age <= 2'h0;
        end else if (age != 2'h3) begin
            age <= age + 2'h1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_outs_zero;
        serial_clock_pin_o == 1'b0 && serial_data_pin_o == 1'b0;
    endproperty
    a_outs_zero: assert property (p_outs_zero)
        else $error("pin out high");
    property p_rst_idle;
        disable iff (1'b0)
        !rst_n |=> serial_clock_pin_oe_n && serial_data_pin_oe_n;
    endproperty
    a_rst_idle: assert property (p_rst_idle)
        else $error("pin held in reset");
    property p_start_pulse;
        start_irq |=> !start_irq;
    endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("start long");
    property p_stop_pulse;
        stop_irq |=> !stop_irq;
    endproperty
    a_stop_pulse: assert property (p_stop_pulse)
        else $error("stop long");
    property p_irq_excl;
        !(start_irq && stop_irq);
    endproperty
    a_irq_excl: assert property (p_irq_excl)
        else $error("both events");
    property p_rd_idle;
        !rd |=> rdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("stray read data");
    property p_force_low;
        ctl[`BCS_C_FLOW] && age == 2'h3 |-> !serial_clock_pin_oe_n;
    endproperty
    a_force_low: assert property (p_force_low)
        else $error("clock free");
    property p_start_gen;
        ctl[`BCS_C_SEL] && start_irq |->
            !serial_clock_pin_oe_n && !serial_data_pin_oe_n;
    endproperty
    a_start_gen: assert property (p_start_gen)
        else $error("bad start");
    property p_stop_gen;
        ctl[`BCS_C_SEL] && stop_irq |->
            serial_clock_pin_oe_n && serial_data_pin_oe_n;
    endproperty
    a_stop_gen: assert property (p_stop_gen)
        else $error("bad stop");
    c_start: cover property (start_irq);
    c_stop: cover property (stop_irq);
    c_force: cover property (ctl[`BCS_C_FLOW] && age == 2'h3);
endmodule
bind bcs_top bcs_sva i_sva (.mclk(mclk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .serial_clock_pin_o(serial_clock_pin_o),
    .serial_clock_pin_oe_n(serial_clock_pin_oe_n),
    .serial_data_pin_o(serial_data_pin_o),
    .serial_data_pin_oe_n(serial_data_pin_oe_n),
    .start_irq(start_irq), .stop_irq(stop_irq));

/* File: tb/bcs_bus_model.sv */
// far side of the two-wire bus: pull-ups and a second master
`timescale 1ns/10ps
module bcs_bus_model (
    // device pin drives
    input wire logic scl_oe_n,
    input wire logic sda_oe_n,
    // resolved wire levels
    output logic scl,
    output logic sda
);
    logic scl_low = 1'b0; // far side pulls clock low
    logic sda_low = 1'b0; // far side pulls data low
    // open drain with pull-ups: any party may pull a line low
    assign scl = scl_oe_n && !scl_low;
    assign sda = sda_oe_n && !sda_low;
    task automatic make_start();
        sda_low = 1'b1;
        #320;
        scl_low = 1'b1;
        #320;
    endtask
    task automatic make_stop();
        sda_low = 1'b1;
        #320;
        scl_low = 1'b0;
        #320;
        sda_low = 1'b0;
        #320;
    endtask
endmodule

/* File: tb/tb.sv */
// self-checking bench for the bus condition and clock block
`timescale 1ns/10ps
`include "bcs_regs.svh"
module tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata, v;
    logic scl_oe_n, sda_oe_n, scl_w, sda_w, start_irq, stop_irq;
    int error_cnt = 0;
    int num_checks = 0;
    logic mon = 1'b0; // byte monitor enable
    logic prev = 1'b0; // clock wire at previous edge
    int hi = 0; // edges in the current clock high run
    logic [8:0] got = 9'h0; // data seen at clock rises
    // control, word, far side pulls data, bits seen, lost flag
    // sync stays off, so the clock source bit may stay 0
    logic [31:0] rows [6][5] = '{
        '{32'h00800, 32'h1a5, 0, 32'h14b, 0},
        '{32'h00800, 32'h1ff, 1, 32'h000, 1},
        '{32'h00800, 32'h1c1, 0, 32'h183, 0},
        '{32'h38000, 32'h1c1, 0, 32'h107, 0},
        '{32'h01800, 32'h100, 0, 32'h1ff, 0},
        '{32'h02800, 32'h1ff, 1, 32'h000, 1}};
    initial forever #20 mclk = ~mclk; // 25 MHz count source
    bcs_top i_dut (.mclk(mclk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .serial_clock_pin_i(scl_w), .serial_clock_pin_o(),
        .serial_clock_pin_oe_n(scl_oe_n), .serial_data_pin_i(sda_w),
        .serial_data_pin_o(), .serial_data_pin_oe_n(sda_oe_n),
        .start_irq(start_irq), .stop_irq(stop_irq));
    bcs_bus_model i_bus (.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n),
        .scl(scl_w), .sda(sda_w));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    // one write cycle on the register port
    task automatic put(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    // one read cycle, data taken in the cycle after the strobe
    task automatic get(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        get(a, d);
        chk(d, e);
    endtask
    // bounded wait for a start or stop event pulse
    task automatic wait_irq(input logic s);
        for (int i = 0; i < 400; i++) begin
            @(posedge mclk);
            #1;
            if ((s ? stop_irq : start_irq) === 1'b1) return;
        end
        chk(32'h0, 32'h1);
    endtask
    // poll busy until the byte is done, bounded
    task automatic wait_idle();
        logic [31:0] s;
        for (int i = 0; i < 400; i++) begin
            get(`BCS_A_STAT, s);
            if (s[`BCS_S_BUSY] === 1'b0) return;
        end
        chk(32'h0, 32'h1);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // wire monitor: data at clock rises, high run length at falls
    always @(posedge mclk) begin
        prev <= scl_w;
        if (mon && scl_w && !prev) got <= {got[7:0], sda_w};
        hi <= (mon && scl_w) ? hi + 1 : 0;
        // high half of baud plus one
        if (mon && !scl_w && prev) chk(hi, 32'h21);
    end
    // watchdog far beyond the expected run of a few thousand cycles
    initial begin
        #1000000;
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        put(8'h10, 32'hffffffff);
        rchk(8'h10, 32'h0);
        rchk(`BCS_A_CTRL, 32'h00800);
        rchk(`BCS_A_BAUD, 32'h18);
        rchk(`BCS_A_TX, 32'h1ff);
        rchk(`BCS_A_STAT, 32'h0c);
        // conditions made by the other master are flagged
        fork
            i_bus.make_start();
            wait_irq(1'b0);
        join
        fork
            i_bus.make_stop();
            wait_irq(1'b1);
        join
        put(`BCS_A_BAUD, 32'h20); // about 379 kbps
        rchk(`BCS_A_BAUD, 32'h20);
        // request first, then select output
        put(`BCS_A_CTRL, 32'h801);
        put(`BCS_A_CTRL, 32'h809);
        wait_irq(1'b0);
        chk({30'h0, scl_w, sda_w}, 32'h0);
        rchk(`BCS_A_CTRL, 32'h808);
        // eighth-bit wait parks the ninth low phase until cleared
        put(`BCS_A_CTRL, 32'h810);
        put(`BCS_A_TX, 32'h1ff);
        repeat (700) @(posedge mclk);
        rchk(`BCS_A_STAT, 32'h1a);
        put(`BCS_A_CTRL, 32'h800);
        wait_idle();
        // bytes: order, delay, arbitration per bit and per byte
        for (int r = 0; r < 6; r++) begin
            put(`BCS_A_CTRL, rows[r][0]);
            i_bus.sda_low = rows[r][2][0];
            mon <= 1'b1;
            put(`BCS_A_TX, rows[r][1]);
            wait_idle();
            mon <= 1'b0;
            i_bus.sda_low = 1'b0;
            chk(got, rows[r][3]);
            get(`BCS_A_STAT, v);
            chk(v[`BCS_S_LOST], rows[r][4]);
        end
        put(`BCS_A_CTRL, 32'h804);
        put(`BCS_A_CTRL, 32'h80c);
        wait_irq(1'b1);
        chk({30'h0, scl_w, sda_w}, 32'h3);
        rchk(`BCS_A_STAT, 32'h0d);
        put(`BCS_A_CTRL, 32'h820);
        repeat (4) @(posedge mclk);
        chk(scl_w, 32'h0);
        put(`BCS_A_CTRL, 32'h800);
        repeat (4) @(posedge mclk);
        chk(scl_w, 32'h1);
        summarize();
    end
endmodule
